/* File: rtl/disk_ctrl_params.svh */
// Register offsets, field positions, reset values and timing counts for the command unit
`ifndef DISK_CTRL_PARAMS_SVH
`define DISK_CTRL_PARAMS_SVH

`define OFS_COMMAND 12'h000
`define OFS_RESULT 12'h004
`define OFS_CONFIG 12'h008
`define OFS_TIMING 12'h00c
`define OFS_STATUS 12'h010
`define OFS_CYLINDER 12'h014
`define OFS_DRIVE 12'h018

`define CFG_EIS_BIT 6
`define CFG_FIFO_DIS_BIT 5
`define CFG_POLL_DIS_BIT 4
`define CFG_RESET 16'h0020
`define PRECOMP_START_TRACK_RESET 8'h00
`define TIMING_RESET 16'h0000

`define ST0_SE_BIT 5
`define ST0_EC_BIT 4
`define ST0_HEAD_BIT 2
`define IC_NORMAL 2'b00
`define IC_ABNORMAL 2'b01
`define IC_POLL 2'b11

`define VERSION_BYTE 8'h5a
`define RECAL_MAX_STEPS 8'd79

// Base unit of the timing tables at the 2 Mbps rate, 0.5 ms
`define BASE_UNIT_NS 500000
`define CLK_PERIOD_NS 10
`define BASE_UNIT_CYCLES (`BASE_UNIT_NS / `CLK_PERIOD_NS)
`define STEP_PULSE_NS 1000
`define STEP_PULSE_CYCLES (`STEP_PULSE_NS / `CLK_PERIOD_NS)

`endif

/* File: rtl/disk_ctrl_pkg.sv */
// Types shared by the disk controller command unit
package disk_ctrl_pkg;
  typedef enum logic [3:0]
  {
    OP_SEEK = 4'h0,
    OP_RECAL = 4'h1,
    OP_REL_SEEK = 4'h2,
    OP_SENSE_INT = 4'h3,
    OP_DRIVE_STATUS = 4'h4,
    OP_SPECIFY = 4'h5,
    OP_CONFIGURE = 4'h6,
    OP_VERSION = 4'h7,
    OP_XFER_DONE = 4'h8,
    OP_XFER_BYTE = 4'h9
  } opcode_t;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'b00001,
    ST_STEP = 5'b00010,
    ST_GAP = 5'b00100,
    ST_DONE = 5'b01000,
    ST_XFER = 5'b10000
  } seek_state_t;

  typedef logic [1:0] rate_t;
endpackage

/* File: rtl/delay_timer.sv */
// Programmable delay counter in data-rate scaled units
`timescale 1ns/1ps
module delay_timer #(
  parameter int UNIT_CYCLES = 50000,
  parameter int CODE_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic [CODE_W-1:0] units,
  input wire disk_ctrl_pkg::rate_t rate,
  output logic busy,
  output logic done
);
  import disk_ctrl_pkg::*;

  logic [31:0] unit_cnt_q;
  logic [CODE_W+2:0] left_q;
  logic [31:0] unit_len;

  // Slower rates stretch each unit by 2, 4 or 8
  assign unit_len = 32'(UNIT_CYCLES) << rate;
  assign busy = left_q != '0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      left_q <= '0;
    else if (start)
      left_q <= {3'b000, units};
    else if (busy && unit_cnt_q == unit_len - 32'd1)
      left_q <= left_q - 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      unit_cnt_q <= '0;
    else if (start || !busy || unit_cnt_q == unit_len - 32'd1)
      unit_cnt_q <= '0;
    else
      unit_cnt_q <= unit_cnt_q + 32'd1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      done <= 1'b0;
    else
      done <= busy && left_q == 1 && unit_cnt_q == unit_len - 32'd1;
  end
endmodule

/* File: rtl/pin_sync.sv */
// Two flip-flop synchroniser for drive pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* File: rtl/disk_ctrl_command_unit.sv */
// Control-command unit of a floppy disk controller with an AHB-Lite register port
`timescale 1ns/1ps
`include "disk_ctrl_params.svh"
module disk_ctrl_command_unit #(
  parameter int UNIT_CYCLES = `BASE_UNIT_CYCLES,
  parameter int PULSE_CYCLES = `STEP_PULSE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire disk_ctrl_pkg::rate_t data_rate,
  input wire logic track_zero_signal,
  input wire logic [7:0] drive_status_pins,
  output logic step_out,
  output logic direction,
  output logic head_load,
  output logic dma_request,
  output logic request_for_master,
  output logic interrupt
);
  import disk_ctrl_pkg::*;

  // ------------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------------
  logic wr_pend_q;
  logic [11:0] addr_q;
  logic wr_go;
  logic rd_go;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign wr_go = wr_pend_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= '0;
    end
    else
    begin
      wr_pend_q <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1])
        addr_q <= haddr[11:0];
    end
  end

  // ------------------------------------------------------------------
  // Pins and timers
  // ------------------------------------------------------------------
  logic trk0_s;
  logic [7:0] drv_s;

  pin_sync #(.W(9)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({track_zero_signal, drive_status_pins}),
    .sync_out({trk0_s, drv_s})
  );

  logic [3:0] step_interval_q;
  logic [3:0] head_unload_delay_q;
  logic [6:0] head_load_delay_q;
  logic no_dma_select_q;
  logic [7:0] cfg_q;
  logic [7:0] precomp_start_track_q;
  logic [7:0] present_cylinder_q;
  logic [7:0] new_cylinder_q;
  logic [7:0] steps_left_q;
  logic [7:0] status_byte_zero_q;
  logic [7:0] result_q;
  logic int_seek_q;
  logic int_result_q;
  logic poll_pend_q;
  logic xfer_need_q;
  logic rel_q;
  logic recal_q;
  logic implied_q;
  logic [31:0] pulse_cnt_q;
  logic first_gap_q;
  seek_state_t state_q;

  logic cmd_wr;
  opcode_t op;
  assign cmd_wr = wr_go && addr_q == `OFS_COMMAND;
  assign op = opcode_t'(hwdata[27:24]);

  logic gap_start;
  logic gap_busy;
  logic gap_done;
  logic [7:0] gap_units;
  logic hlt_start;
  logic hlt_busy;
  logic hlt_done;
  logic hut_start;
  logic hut_busy;

  // Step interval code 0 means 16 units; first gap is one unit shorter except with code 1
  assign gap_units = 8'({~|step_interval_q, step_interval_q}) - {7'h0, first_gap_q && step_interval_q != 4'h1};

  delay_timer #(.UNIT_CYCLES(UNIT_CYCLES), .CODE_W(8)) u_step (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(gap_start),
    .units(gap_units),
    .rate(data_rate),
    .busy(gap_busy),
    .done(gap_done)
  );

  delay_timer #(.UNIT_CYCLES(UNIT_CYCLES), .CODE_W(8)) u_load (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(hlt_start),
    .units({~|head_load_delay_q, head_load_delay_q}),
    .rate(data_rate),
    .busy(hlt_busy),
    .done(hlt_done)
  );

  delay_timer #(.UNIT_CYCLES(UNIT_CYCLES * 16), .CODE_W(8)) u_unload (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(hut_start),
    .units({3'b000, ~|head_unload_delay_q, head_unload_delay_q}),
    .rate(data_rate),
    .busy(hut_busy),
    .done()
  );

  // ------------------------------------------------------------------
  // Parameter registers
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      step_interval_q <= 4'(`TIMING_RESET);
      head_unload_delay_q <= '0;
      head_load_delay_q <= '0;
      no_dma_select_q <= 1'b0;
    end
    else if (cmd_wr && op == OP_SPECIFY)
    begin
      step_interval_q <= hwdata[7:4];
      head_unload_delay_q <= hwdata[3:0];
      head_load_delay_q <= hwdata[15:9];
      no_dma_select_q <= hwdata[8];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_q <= 8'(`CFG_RESET);
      precomp_start_track_q <= `PRECOMP_START_TRACK_RESET;
    end
    else if (cmd_wr && op == OP_CONFIGURE)
    begin
      cfg_q <= hwdata[7:0];
      precomp_start_track_q <= hwdata[15:8];
    end
  end

  // ------------------------------------------------------------------
  // Seek engine
  // ------------------------------------------------------------------
  logic seek_cmd;
  assign seek_cmd = cmd_wr && state_q == ST_IDLE
    && (op == OP_SEEK || op == OP_RECAL || op == OP_REL_SEEK || op == OP_XFER_DONE);
  assign gap_start = state_q == ST_STEP && pulse_cnt_q == 32'(PULSE_CYCLES - 1);
  assign hlt_start = cmd_wr && op == OP_XFER_BYTE && !head_load;
  assign hut_start = state_q == ST_XFER && cmd_wr && op == OP_XFER_DONE;

  logic more_steps;
  assign more_steps = recal_q ? !trk0_s && steps_left_q != 8'd0
    : steps_left_q != 8'd0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= ST_IDLE;
      steps_left_q <= '0;
      direction <= 1'b0;
      rel_q <= 1'b0;
      recal_q <= 1'b0;
      implied_q <= 1'b0;
      first_gap_q <= 1'b0;
      pulse_cnt_q <= '0;
      present_cylinder_q <= '0;
      new_cylinder_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          first_gap_q <= 1'b1;
          pulse_cnt_q <= '0;
          if (cmd_wr && op == OP_XFER_BYTE)
          begin
            new_cylinder_q <= hwdata[7:0];
            if (cfg_q[`CFG_EIS_BIT] && hwdata[7:0] != present_cylinder_q)
            begin
              implied_q <= 1'b1;
              rel_q <= 1'b0;
              recal_q <= 1'b0;
              direction <= present_cylinder_q < hwdata[7:0];
              steps_left_q <= present_cylinder_q < hwdata[7:0]
                ? hwdata[7:0] - present_cylinder_q : present_cylinder_q - hwdata[7:0];
              state_q <= ST_STEP;
            end
            else
              state_q <= ST_XFER;
          end
          else if (seek_cmd && op == OP_SEEK)
          begin
            new_cylinder_q <= hwdata[7:0];
            rel_q <= 1'b0;
            recal_q <= 1'b0;
            implied_q <= 1'b0;
            direction <= present_cylinder_q < hwdata[7:0];
            steps_left_q <= present_cylinder_q < hwdata[7:0]
              ? hwdata[7:0] - present_cylinder_q : present_cylinder_q - hwdata[7:0];
            state_q <= hwdata[7:0] == present_cylinder_q ? ST_DONE : ST_STEP;
          end
          else if (seek_cmd && op == OP_RECAL)
          begin
            rel_q <= 1'b0;
            recal_q <= 1'b1;
            implied_q <= 1'b0;
            direction <= 1'b0;
            present_cylinder_q <= '0;
            steps_left_q <= `RECAL_MAX_STEPS;
            state_q <= ST_STEP;
          end
          else if (seek_cmd && op == OP_REL_SEEK)
          begin
            rel_q <= 1'b1;
            recal_q <= 1'b0;
            implied_q <= 1'b0;
            direction <= hwdata[8];
            steps_left_q <= hwdata[7:0];
            state_q <= hwdata[7:0] == 8'd0 ? ST_DONE : ST_STEP;
          end
        end
        ST_STEP:
        begin
          if (recal_q && trk0_s)
            state_q <= ST_DONE;
          else if (pulse_cnt_q == 32'(PULSE_CYCLES - 1))
          begin
            pulse_cnt_q <= '0;
            steps_left_q <= steps_left_q - 8'd1;
            if (!recal_q)
              present_cylinder_q <= direction ? present_cylinder_q + 8'd1
                : present_cylinder_q - 8'd1;
            state_q <= ST_GAP;
          end
          else
            pulse_cnt_q <= pulse_cnt_q + 32'd1;
        end
        ST_GAP:
          if (gap_done)
          begin
            first_gap_q <= 1'b0;
            state_q <= more_steps ? ST_STEP : (implied_q ? ST_XFER : ST_DONE);
          end
        ST_DONE:
          state_q <= ST_IDLE;
        ST_XFER:
          if (cmd_wr && op == OP_XFER_DONE)
            state_q <= ST_IDLE;
      endcase
    end
  end

  assign step_out = state_q == ST_STEP && !(recal_q && trk0_s);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      head_load <= 1'b0;
    else if (hlt_start)
      head_load <= 1'b1;
    else if (!hut_busy && !hlt_busy && state_q == ST_IDLE && !hut_start)
      head_load <= head_load && hut_start;
  end

  // ------------------------------------------------------------------
  // Status byte zero, interrupt causes
  // ------------------------------------------------------------------
  logic sense;
  assign sense = cmd_wr && op == OP_SENSE_INT;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_byte_zero_q <= 8'h00;
    else if (state_q == ST_DONE)
    begin
      status_byte_zero_q[`ST0_SE_BIT] <= 1'b1;
      status_byte_zero_q[`ST0_HEAD_BIT] <= 1'b0;
      status_byte_zero_q[7:6] <= recal_q && !trk0_s ? `IC_ABNORMAL : `IC_NORMAL;
      status_byte_zero_q[`ST0_EC_BIT] <= (recal_q && !trk0_s)
        || (rel_q && !direction && trk0_s && steps_left_q == 8'd0 && present_cylinder_q != 8'd0);
    end
    else if (rel_q && state_q == ST_GAP && !direction && trk0_s)
      status_byte_zero_q[`ST0_EC_BIT] <= 1'b1;
    else if (poll_pend_q && !int_seek_q)
      status_byte_zero_q <= {`IC_POLL, 6'b000000};
  end

  // Polling waits while the head is loaded and unload delay still runs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      poll_pend_q <= 1'b1;
    else if (poll_pend_q && !(head_load && hut_busy))
      poll_pend_q <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_seek_q <= 1'b0;
    else if (state_q == ST_DONE && !implied_q)
      int_seek_q <= 1'b1;
    else if (poll_pend_q && !(head_load && hut_busy) && !cfg_q[`CFG_POLL_DIS_BIT])
      int_seek_q <= 1'b1;
    else if (sense)
      int_seek_q <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_result_q <= 1'b0;
    else if (hut_start)
      int_result_q <= 1'b1;
    else if ((rd_go && haddr[11:0] == `OFS_RESULT) || sense)
      int_result_q <= 1'b0;
  end

  // Byte need after head load settles, as DMA request or, with no DMA selected, master request; single bytes whatever the FIFO bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      xfer_need_q <= 1'b0;
    else if (state_q == ST_XFER && !hlt_busy && !xfer_need_q && !(cmd_wr && op == OP_XFER_BYTE))
      xfer_need_q <= 1'b1;
    else if ((cmd_wr && op == OP_XFER_BYTE) || state_q != ST_XFER)
      xfer_need_q <= 1'b0;
  end

  assign request_for_master = no_dma_select_q && xfer_need_q;
  assign dma_request = !no_dma_select_q && xfer_need_q;
  assign interrupt = int_seek_q || int_result_q || request_for_master;

  // ------------------------------------------------------------------
  // Result byte and read mux
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      result_q <= '0;
    else if (sense)
      result_q <= status_byte_zero_q;
    else if (cmd_wr && op == OP_DRIVE_STATUS)
      result_q <= {drv_s[7:5], trk0_s, drv_s[3:0]};
    else if (cmd_wr && op == OP_VERSION)
      result_q <= `VERSION_BYTE;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (rd_go)
      unique case (haddr[11:0])
        `OFS_RESULT: hrdata <= {24'h0, result_q};
        `OFS_CONFIG: hrdata <= {16'h0, precomp_start_track_q, cfg_q};
        `OFS_TIMING: hrdata <= {16'h0, head_load_delay_q, no_dma_select_q,
          step_interval_q, head_unload_delay_q};
        `OFS_STATUS: hrdata <= {24'h0, status_byte_zero_q};
        `OFS_CYLINDER: hrdata <= {16'h0, new_cylinder_q, present_cylinder_q};
        `OFS_DRIVE: hrdata <= {24'h0, 3'b000, state_q};
        default: hrdata <= '0;
      endcase
  end
endmodule

/* File: testbench/disk_drive_model.sv */
// Behavioural floppy drive: head position, track zero sensor and status pins
`timescale 1ns/1ps
module disk_drive_model #(
  parameter logic [7:0] STATUS_BITS = 8'h3c
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic step_out,
  input wire logic direction,
  output logic track_zero_signal,
  output logic [7:0] drive_status_pins,
  output logic [9:0] head_pos
);
  logic step_q;
  // ----------------------------------------
  // Head mechanics
  // ----------------------------------------
  // Position is physical, so it may run past 255 where the cylinder register wraps
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      step_q <= 1'b0;
      head_pos <= 10'h000;
    end
    else
    begin
      step_q <= step_out;
      if (step_out && !step_q && direction)
        head_pos <= head_pos + 10'h001;
      else if (step_out && !step_q && head_pos != 10'h000)
        head_pos <= head_pos - 10'h001;
    end
  end
  assign track_zero_signal = (head_pos == 10'h000);
  assign drive_status_pins = STATUS_BITS;
endmodule

/* File: testbench/disk_ctrl_command_unit_asserts.sv */
// Port-level checker for the command unit
`timescale 1ns/1ps
`include "disk_ctrl_params.svh"
module disk_ctrl_command_unit_chk #(
  parameter int PULSE_CYCLES = 100
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic step_out,
  input wire logic direction,
  input wire logic interrupt,
  input wire logic dma_request
);
  logic ph_q;
  logic wr_q;
  logic [11:0] adr_q;
  logic [7:0] hi_cnt_q;
  logic [2:0] age_q;
  logic rd_ph;
  assign rd_ph = hsel && hready && htrans[1] && !hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_q <= 1'b0;
      wr_q <= 1'b0;
      adr_q <= 12'h000;
      hi_cnt_q <= 8'h00;
      age_q <= 3'h7;
    end
    else
    begin
      ph_q <= hsel && hready && htrans[1];
      wr_q <= hwrite;
      adr_q <= haddr[11:0];
      hi_cnt_q <= step_out ? hi_cnt_q + 8'h01 : 8'h00;
      // A command write or result read counts as servicing the interrupt
      if (ph_q && (wr_q ? adr_q == `OFS_COMMAND : adr_q == `OFS_RESULT))
        age_q <= 3'h0;
      else if (age_q != 3'h7)
        age_q <= age_q + 3'h1;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_step_pulse_width: assert property ($fell(step_out) |-> hi_cnt_q == PULSE_CYCLES)
    else $error("step pulse width wrong");
  a_dir_stable_step: assert property (step_out && $past(step_out) |-> $stable(direction))
    else $error("direction moved during a step pulse");
  a_sense_clears_irq: assert property (ph_q && wr_q && adr_q == `OFS_COMMAND
    && hwdata[27:24] == 4'h3 |=> !interrupt)
    else $error("sense command left interrupt high");
  a_irq_held_serviced: assert property ($fell(interrupt) |-> age_q < 3'h4)
    else $error("interrupt dropped without service");
  a_unmapped_read_zero: assert property (rd_ph && haddr[11:0] > `OFS_DRIVE |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_head_bit_zero: assert property (rd_ph && haddr[11:0] == `OFS_STATUS |=> !hrdata[`ST0_HEAD_BIT])
    else $error("head bit of status byte set");
  a_resp_always_okay: assert property (!hresp)
    else $error("error response");
  a_ready_always_high: assert property (hreadyout)
    else $error("wait state inserted");
  c_step: cover property ($rose(step_out));
  c_irq: cover property ($rose(interrupt));
  c_dma: cover property ($rose(dma_request));
endmodule

bind disk_ctrl_command_unit disk_ctrl_command_unit_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .step_out(step_out), .direction(direction),
  .interrupt(interrupt), .dma_request(dma_request)
);

/* File: testbench/disk_ctrl_command_unit_test.sv */
// Register-level testbench for the command unit
`timescale 1ns/1ps
`include "disk_ctrl_params.svh"
module disk_ctrl_command_unit_test;
  import disk_ctrl_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  rate_t data_rate = 2'b00;
  logic [31:0] hrdata;
  logic hreadyout, hresp, track_zero_signal, step_out, direction, head_load;
  logic dma_request, request_for_master, interrupt;
  logic [7:0] drive_status_pins;
  logic [9:0] head_pos;
  logic [31:0] rd;
  int error_cnt = 0;
  int total_checks = 0;
  always #5 hclk = ~hclk;
  disk_ctrl_command_unit #(.UNIT_CYCLES(4), .PULSE_CYCLES(2)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .data_rate(data_rate),
    .track_zero_signal(track_zero_signal), .drive_status_pins(drive_status_pins),
    .step_out(step_out), .direction(direction), .head_load(head_load),
    .dma_request(dma_request), .request_for_master(request_for_master), .interrupt(interrupt)
  );
  disk_drive_model #(.STATUS_BITS(8'h3c)) u_drive (
    .hclk(hclk), .hresetn(hresetn), .step_out(step_out), .direction(direction),
    .track_zero_signal(track_zero_signal), .drive_status_pins(drive_status_pins),
    .head_pos(head_pos)
  );
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 100)
    begin
      @(posedge hclk);
      n++;
    end
    if (hreadyout !== 1'b1)
    begin
      chk("hready", hreadyout, 1);
      print_verdict();
    end
  endtask
  // Address phase, then data phase; read data is taken at the closing edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic cmd(input opcode_t op, input logic [23:0] args);
    xfer(1'b1, `OFS_COMMAND, {4'h0, op, args});
  endtask
  // Bounded wait on the interrupt (sel 0) or the DMA request (sel 1)
  task automatic wait_for(input bit sel);
    int n;
    n = 0;
    while ((sel ? dma_request : interrupt) !== 1'b1 && n < 40000)
    begin
      @(posedge hclk);
      n++;
    end
    if ((sel ? dma_request : interrupt) !== 1'b1)
    begin
      chk("wait", 0, 1);
      print_verdict();
    end
  endtask
  // Motion command, then the mandatory sense; status byte compared under a mask
  task automatic move(input opcode_t op, input logic [23:0] args, input logic [7:0] mask,
    input logic [7:0] st0, input logic [9:0] pos, input logic [7:0] cyl);
    cmd(op, args);
    wait_for(0);
    cmd(OP_SENSE_INT, 24'h0);
    xfer(1'b0, `OFS_RESULT, 32'h0);
    chk("status byte zero", rd[7:0] & mask, st0);
    chk("interrupt cleared", interrupt, 0);
    chk("head position", head_pos, pos);
    xfer(1'b0, `OFS_CYLINDER, 32'h0);
    chk("present cylinder", rd[7:0], cyl);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    wait_for(0);
    cmd(OP_SENSE_INT, 24'h0);
    xfer(1'b0, `OFS_STATUS, 32'h0);
    chk("poll cause", rd[7:0] & 8'he4, 8'hc0);
    chk("interrupt cleared", interrupt, 0);
    xfer(1'b0, `OFS_CONFIG, 32'h0);
    chk("config reset", rd[15:0], {`PRECOMP_START_TRACK_RESET, 8'h20});
    cmd(OP_CONFIGURE, 24'h00ff0f);
    xfer(1'b0, `OFS_CONFIG, 32'h0);
    chk("config max", rd[15:0], 16'hff0f);
    cmd(OP_CONFIGURE, 24'h000020);
    xfer(1'b0, `OFS_CONFIG, 32'h0);
    chk("config restore", rd[15:0], 16'h0020);
    cmd(OP_VERSION, 24'h0);
    xfer(1'b0, `OFS_RESULT, 32'h0);
    chk("version", rd[7:0], `VERSION_BYTE);
    cmd(OP_DRIVE_STATUS, 24'h0);
    xfer(1'b0, `OFS_RESULT, 32'h0);
    chk("drive status", rd[7:0], 8'h3c);
    xfer(1'b0, 12'h0ff, 32'h0);
    chk("unmapped", rd, 32'h0);
    cmd(OP_SPECIFY, 24'h0002f1);
    move(OP_SEEK, 24'h000005, 8'hf4, 8'h20, 10'd5, 8'd5);
    move(OP_SEEK, 24'h000002, 8'hf4, 8'h20, 10'd2, 8'd2);
    move(OP_REL_SEEK, 24'h0001ff, 8'h30, 8'h20, 10'd257, 8'd1);
    move(OP_REL_SEEK, 24'h0000ff, 8'h30, 8'h20, 10'd2, 8'd2);
    move(OP_RECAL, 24'h0, 8'hf4, 8'h20, 10'd0, 8'd0);
    move(OP_REL_SEEK, 24'h000002, 8'h30, 8'h30, 10'd0, 8'd254);
    move(OP_RECAL, 24'h0, 8'hf4, 8'h20, 10'd0, 8'd0);
    data_rate <= 2'd1;
    move(OP_SEEK, 24'h000064, 8'hf4, 8'h20, 10'd100, 8'd100);
    move(OP_RECAL, 24'h0, 8'hf4, 8'h70, 10'd21, 8'd0);
    cmd(OP_SPECIFY, 24'h0003f1);
    xfer(1'b0, `OFS_TIMING, 32'h0);
    chk("timing", rd[15:0], 16'h03f1);
    cmd(OP_XFER_BYTE, 24'h0);
    wait_for(0);
    chk("master request", request_for_master, 1);
    chk("head loaded", head_load, 1);
    chk("dma idle", dma_request, 0);
    cmd(OP_XFER_DONE, 24'h0);
    @(posedge hclk);
    chk("result interrupt", interrupt, 1);
    xfer(1'b0, `OFS_RESULT, 32'h0);
    @(posedge hclk);
    chk("interrupt after read", interrupt, 0);
    cmd(OP_SPECIFY, 24'h0002f1);
    cmd(OP_CONFIGURE, 24'h000060);
    cmd(OP_XFER_BYTE, 24'h000003);
    wait_for(1);
    xfer(1'b0, `OFS_CYLINDER, 32'h0);
    chk("implied seek cylinder", rd[15:0], 16'h0303);
    chk("implied seek head", head_pos, 10'd24);
    chk("no byte interrupt", interrupt, 0);
    cmd(OP_XFER_DONE, 24'h0);
    @(posedge hclk);
    chk("result interrupt", interrupt, 1);
    xfer(1'b0, `OFS_RESULT, 32'h0);
    @(posedge hclk);
    chk("interrupt after read", interrupt, 0);
    print_verdict();
  end
endmodule
